/* src/dac_cmd_defs.svh */
/*
 * Named constants of the serial converter command logic: word layout,
 * command and subcommand codes, clear codes and counter widths.
 * Assumes it is included by bare name, once per compilation unit use.
 */
`ifndef DAC_CMD_DEFS_SVH
`define DAC_CMD_DEFS_SVH

// ***********************************************************************
// word layout
// ***********************************************************************
`define WORD_BITS      16
`define DATA_BITS      14
`define CNT_W          5
`define WORD_CNT_FULL  5'h10
`define WORD_MSB       15

// ***********************************************************************
// command codes (high bit, low bit)
// ***********************************************************************
`define CMD_LOAD_IN    2'h0
`define CMD_LOAD_BOTH  2'h1
`define CMD_UPDATE     2'h2
`define CMD_SUB        2'h3

// ***********************************************************************
// subcommand codes in data bits 13 and 12
// ***********************************************************************
`define SUB_NOP        2'h0
`define SUB_HW_POWER_OFF_PIN       2'h1
`define SUB_UPO        2'h2
`define SUB_MODE       2'h3
`define SUB_HI         13
`define SUB_LO         12
`define SUB_ARG        11

// ***********************************************************************
// clear codes and reset values
// ***********************************************************************
`define CLR_ZERO_CODE  14'h0000
`define CLR_MID_CODE   14'h2000
`define UPO_DEFAULT    1'h0

`endif

/* src/dac_cmd_pkg.sv */
/*
 * Types shared by the converter command logic: the received word, the
 * group of sampled pins and the shift-out mode.
 * Assumes dac_cmd_defs.svh is on the include path.
 */
`include "dac_cmd_defs.svh"

package dac_cmd_pkg;

    // received word, most significant bit first on the line
    typedef struct packed {
        logic                  command_bit_high;
        logic                  command_bit_low;
        logic [`DATA_BITS-1:0] word_data_field;
    } cmd_word_t;

    // pins as they arrive, and after synchronising
    typedef struct packed {
        logic serial_clk;
        logic chip_select_n;
        logic serial_din;
        logic async_clear_input_n;
        logic clear_level_select;
        logic shutdown_lockout;
        logic hw_power_off_pin;
    } pin_bus_t;

    // edge on which the shift-out pin changes
    typedef enum logic {
        DOUT_MODE0_FALL,
        DOUT_MODE1_RISE
    } dout_mode_t;

endpackage

/* src/pin_sync.sv */
/*
 * Two flip-flop synchroniser for a bundle of asynchronous pins.
 * Assumes each bit is an independent level; no bus coherency is kept.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage is read only by the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

`default_nettype wire

/* src/serial_dac_command_logic.sv */
/*
 * Command logic of a 14-bit serial converter: oversampled serial port,
 * double-buffered code registers, subcommands, clear and shift-out pin.
 * Assumes clk runs well above four times the serial clock rate and that
 * every pin input is asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmd_defs.svh"

module serial_dac_command_logic (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // serial link from the host
    input  wire logic                  serial_clk,
    input  wire logic                  chip_select_n,
    input  wire logic                  serial_din,
    output logic                       serial_dout,
    // control pins
    input  wire logic                  async_clear_input_n,
    input  wire logic                  clear_level_select,
    input  wire logic                  shutdown_lockout,
    input  wire logic                  hw_power_off_pin,
    // converter side
    output logic [`DATA_BITS-1:0]      dac_code,
    output logic                       shutdown_active,
    output logic                       user_logic_output
);

    // ***********************************************************************
    // pin sampling
    // ***********************************************************************
    dac_cmd_pkg::pin_bus_t   pins_raw;
    dac_cmd_pkg::pin_bus_t   pins_s;
    logic                    sclk_q_ff;
    logic                    cs_q_ff;
    logic                    lock_q_ff;
    logic                    sclk_rise;
    logic                    sclk_fall;
    logic                    cs_rise;
    logic                    lock_fall;

    assign pins_raw = '{serial_clk, chip_select_n, serial_din,
                        async_clear_input_n, clear_level_select,
                        shutdown_lockout, hw_power_off_pin};

    pin_sync #(
        .WIDTH ($bits(dac_cmd_pkg::pin_bus_t))
    ) u_pin_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    // delayed copies for edge detection; select idles high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q_ff <= 1'h0;
            cs_q_ff   <= 1'h1;
            lock_q_ff <= 1'h0;
        end else begin
            sclk_q_ff <= pins_s.serial_clk;
            cs_q_ff   <= pins_s.chip_select_n;
            lock_q_ff <= pins_s.shutdown_lockout;
        end
    end

    assign sclk_rise = pins_s.serial_clk & ~sclk_q_ff;
    assign sclk_fall = ~pins_s.serial_clk & sclk_q_ff;
    assign cs_rise   = pins_s.chip_select_n & ~cs_q_ff;
    assign lock_fall = ~pins_s.shutdown_lockout & lock_q_ff;

    // ***********************************************************************
    // shift register and bit counter
    // ***********************************************************************
    logic [`WORD_BITS-1:0]   shift_ff;
    logic [`CNT_W-1:0]       bit_cnt_ff;
    logic                    word_act;
    dac_cmd_pkg::cmd_word_t  word;
    logic [1:0]              cmd;
    logic [1:0]              sub;

    // msb first, packets join while select is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_ff <= '0;
        end else if (sclk_rise && !pins_s.chip_select_n) begin
            shift_ff <= {shift_ff[`WORD_BITS-2:0], pins_s.serial_din};
        end
    end

    // counter saturates so long chains still hold the last word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_ff <= '0;
        end else if (pins_s.chip_select_n) begin
            bit_cnt_ff <= '0;
        end else if (sclk_rise && bit_cnt_ff != `WORD_CNT_FULL) begin
            bit_cnt_ff <= bit_cnt_ff + `CNT_W'(1);
        end
    end

    // act at select rise, partial words dropped
    // with more than 16 bits the last word stays
    assign word_act = cs_rise && (bit_cnt_ff == `WORD_CNT_FULL);
    assign word     = dac_cmd_pkg::cmd_word_t'(shift_ff);
    assign cmd      = {word.command_bit_high, word.command_bit_low};
    assign sub      = word.word_data_field[`SUB_HI:`SUB_LO];

    // ***********************************************************************
    // double-buffered code registers
    // ***********************************************************************
    logic [`DATA_BITS-1:0]   input_reg_ff;
    logic [`DATA_BITS-1:0]   dac_code_ff;

    // input register load on 00 or 01
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            input_reg_ff <= `CLR_ZERO_CODE;
        end else if (word_act &&
                     (cmd == `CMD_LOAD_IN || cmd == `CMD_LOAD_BOTH)) begin
            input_reg_ff <= word.word_data_field;
        end
    end

    // clear is a level and wins over any command in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_code_ff <= `CLR_ZERO_CODE;
        end else if (!pins_s.async_clear_input_n) begin
            dac_code_ff <= pins_s.clear_level_select ? `CLR_MID_CODE
                                                     : `CLR_ZERO_CODE;
        end else if (word_act && cmd == `CMD_LOAD_BOTH) begin
            dac_code_ff <= word.word_data_field;
        end else if (word_act && cmd == `CMD_UPDATE) begin
            dac_code_ff <= input_reg_ff;
        end
    end

    // ***********************************************************************
    // subcommand state
    // ***********************************************************************
    logic                    upo_ff;
    dac_cmd_pkg::dout_mode_t mode_ff;
    logic                    hw_power_off_pin_ff;
    logic                    sub_act;

    assign sub_act = word_act && cmd == `CMD_SUB;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upo_ff <= `UPO_DEFAULT;
        end else if (!pins_s.async_clear_input_n) begin
            upo_ff <= `UPO_DEFAULT;
        end else if (sub_act && sub == `SUB_UPO) begin
            upo_ff <= word.word_data_field[`SUB_ARG];
        end
    end

    // argument 0 picks mode 1, 1 picks mode 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= dac_cmd_pkg::DOUT_MODE0_FALL;
        end else if (sub_act && sub == `SUB_MODE) begin
            mode_ff <= word.word_data_field[`SUB_ARG]
                       ? dac_cmd_pkg::DOUT_MODE0_FALL
                       : dac_cmd_pkg::DOUT_MODE1_RISE;
        end
    end

    // shutdown entry gated by lockout
    // lockout low in a falling cycle, so entry cannot race the exit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_power_off_pin_ff <= 1'h0;
        end else if (lock_fall) begin
            hw_power_off_pin_ff <= 1'h0;
        end else if (pins_s.shutdown_lockout &&
                     ((sub_act && sub == `SUB_HW_POWER_OFF_PIN) ||
                      pins_s.hw_power_off_pin)) begin
            hw_power_off_pin_ff <= 1'h1;
        end else if (word_act && cmd == `CMD_LOAD_BOTH) begin
            hw_power_off_pin_ff <= 1'h0;
        end
    end

    // ***********************************************************************
    // shift-out pin
    // ***********************************************************************
    logic                    dout_ff;

    // mode 0 on fall (16), mode 1 on rise (16.5)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_ff <= 1'h0;
        end else if (mode_ff == dac_cmd_pkg::DOUT_MODE0_FALL
                     ? sclk_fall : sclk_rise) begin
            dout_ff <= shift_ff[`WORD_MSB];
        end
    end

    // code passes on as unsigned straight binary
    assign dac_code          = dac_code_ff;
    assign shutdown_active   = hw_power_off_pin_ff;
    assign user_logic_output = upo_ff;
    assign serial_dout       = dout_ff;

    // ***********************************************************************
    // assertions
    // ***********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    load_in_a: assert property (word_act && cmd == `CMD_LOAD_IN &&
        pins_s.async_clear_input_n |=> input_reg_ff ==
        $past(word.word_data_field) && $stable(dac_code_ff))
        else $error("load input changed converter or missed data");
    load_both_a: assert property (word_act &&
        cmd == `CMD_LOAD_BOTH && pins_s.async_clear_input_n |=>
        dac_code_ff == input_reg_ff &&
        dac_code_ff == $past(word.word_data_field))
        else $error("load both did not update both registers");
    update_a: assert property (word_act && cmd == `CMD_UPDATE &&
        pins_s.async_clear_input_n |=> dac_code_ff == $past(input_reg_ff)
        && $stable(input_reg_ff))
        else $error("update did not copy input register");
    hw_power_off_pin_enter_a: assert property (sub_act &&
        sub == `SUB_HW_POWER_OFF_PIN && pins_s.shutdown_lockout |=> hw_power_off_pin_ff)
        else $error("shutdown not entered");
    hw_power_off_pin_lock_a: assert property (!hw_power_off_pin_ff &&
        !pins_s.shutdown_lockout |=> !hw_power_off_pin_ff)
        else $error("shutdown entered while locked out");
    upo_set_a: assert property (sub_act && sub == `SUB_UPO &&
        pins_s.async_clear_input_n |=>
        upo_ff == $past(word.word_data_field[`SUB_ARG]))
        else $error("user output level wrong");
    mode_set_a: assert property (sub_act && sub == `SUB_MODE |=>
        (mode_ff == dac_cmd_pkg::DOUT_MODE0_FALL) ==
        $past(word.word_data_field[`SUB_ARG]))
        else $error("shift-out mode wrong");
    dout_lag_a: assert property (sclk_fall &&
        mode_ff == dac_cmd_pkg::DOUT_MODE0_FALL |=>
        dout_ff == $past(shift_ff[`WORD_MSB]))
        else $error("shift-out pin did not follow");
    hw_power_off_pin_upo_a: assert property (hw_power_off_pin_ff && !sub_act &&
        pins_s.async_clear_input_n |=> $stable(upo_ff))
        else $error("user output moved in shutdown");
    clr_level_a: assert property (!pins_s.async_clear_input_n |=>
        !upo_ff && dac_code_ff == ($past(pins_s.clear_level_select)
        ? `CLR_MID_CODE : `CLR_ZERO_CODE))
        else $error("clear value wrong");
    lock_exit_a: assert property (lock_fall |=> !hw_power_off_pin_ff)
        else $error("lockout fall did not leave shutdown");
    partial_a: assert property (cs_rise &&
        bit_cnt_ff != `WORD_CNT_FULL && pins_s.async_clear_input_n |=>
        $stable(input_reg_ff) && $stable(dac_code_ff) && $stable(upo_ff))
        else $error("partial word acted on");

    load_c:  cover property (word_act && cmd == `CMD_LOAD_BOTH);
    hw_power_off_pin_c:  cover property (hw_power_off_pin_ff ##1 lock_fall ##1 !hw_power_off_pin_ff);
    mode1_c: cover property (mode_ff == dac_cmd_pkg::DOUT_MODE1_RISE &&
                             sclk_rise);
    clr_c:   cover property (!pins_s.async_clear_input_n &&
                             pins_s.clear_level_select);

endmodule

`default_nettype wire

/* testbench/serial_host.sv */
/*
 * Host-side serial master that drives select, clock and data.
 * Assumes clk is the 50 MHz bench clock; the serial period is 8 clk.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_host (
    // bench clock
    input  wire logic        clk,
    // link from the device
    input  wire logic        serial_dout,
    // link to the device
    output logic             serial_clk,
    output logic             chip_select_n,
    output logic             serial_din
);
    // ******************************************************************
    // shift-out samples, mid-high and mid-low of each bit
    // ******************************************************************
    logic [31:0] rx_hi;
    logic [31:0] rx_lo;

    // idle link: select high, clock still
    initial begin
        serial_clk    = 1'h0;
        chip_select_n = 1'h1;
        serial_din    = 1'h0;
        rx_hi         = 32'h0;
        rx_lo         = 32'h0;
    end

    // MSB first, n bits, own select
    task automatic frame(input logic [31:0] bits, input int n,
                         input int gap_at);
        @(negedge clk);
        chip_select_n = 1'h0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            // clock stands still between two packets
            if (i == gap_at) repeat (12) @(negedge clk);
            serial_din = bits[31-i];
            repeat (2) @(negedge clk);
            rx_lo = {rx_lo[30:0], serial_dout};
            repeat (2) @(negedge clk);
            serial_clk = 1'h1;
            repeat (2) @(negedge clk);
            rx_hi = {rx_hi[30:0], serial_dout};
            repeat (2) @(negedge clk);
            serial_clk = 1'h0;
        end
        repeat (4) @(negedge clk);
        chip_select_n = 1'h1;
        // released line must not keep showing the last bit
        serial_din = ~serial_din;
        repeat (8) @(negedge clk);
    endtask
endmodule

`default_nettype wire

/* testbench/serial_dac_command_logic_bench.sv */
/*
 * Self-checking bench of the converter command logic, random words
 * mixed with corner cases. Assumes the host model in serial_host.sv.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmd_defs.svh"

module serial_dac_command_logic_bench;
    // ******************************************************************
    // signals
    // ******************************************************************
    logic        clk;
    logic        rst_n;
    logic        async_clear_input_n;
    logic        clear_level_select;
    logic        shutdown_lockout;
    logic        hw_power_off_pin;
    logic        serial_clk;
    logic        chip_select_n;
    logic        serial_din;
    logic        serial_dout;
    logic [13:0] dac_code;
    logic        shutdown_active;
    logic        user_logic_output;
    logic [13:0] exp_in;
    logic [13:0] exp_dac;
    logic        exp_upo;
    logic        exp_hw_power_off_pin;
    logic [15:0] w;
    logic [15:0] w1;
    logic [15:0] sub_list [5];
    int          n_mismatch;
    int          comparisons;

    // 50 MHz clock
    always #10 clk = ~clk;

    serial_dac_command_logic serial_dac_command_logic_i (
        .clk                 (clk),
        .rst_n               (rst_n),
        .serial_clk          (serial_clk),
        .chip_select_n       (chip_select_n),
        .serial_din          (serial_din),
        .serial_dout         (serial_dout),
        .async_clear_input_n (async_clear_input_n),
        .clear_level_select  (clear_level_select),
        .shutdown_lockout    (shutdown_lockout),
        .hw_power_off_pin    (hw_power_off_pin),
        .dac_code            (dac_code),
        .shutdown_active     (shutdown_active),
        .user_logic_output   (user_logic_output)
    );

    serial_host serial_host_i (
        .clk           (clk),
        .serial_dout   (serial_dout),
        .serial_clk    (serial_clk),
        .chip_select_n (chip_select_n),
        .serial_din    (serial_din)
    );

    // ******************************************************************
    // checking and prediction
    // ******************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] expct);
        comparisons++;
        if (seen !== expct) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expct);
        end
    endtask

    // expected register state after one accepted word
    function automatic void predict(input logic [15:0] word);
        dac_cmd_pkg::cmd_word_t cw;
        cw = word;
        case ({cw.command_bit_high, cw.command_bit_low})
            `CMD_LOAD_IN: exp_in = cw.word_data_field;
            `CMD_LOAD_BOTH: begin
                exp_in   = cw.word_data_field;
                exp_dac  = cw.word_data_field;
                exp_hw_power_off_pin = 1'h0;
            end
            `CMD_UPDATE: exp_dac = exp_in;
            default: begin
                case (cw.word_data_field[`SUB_HI:`SUB_LO])
                    `SUB_HW_POWER_OFF_PIN: if (shutdown_lockout) exp_hw_power_off_pin = 1'h1;
                    `SUB_UPO: exp_upo = cw.word_data_field[`SUB_ARG];
                    default: ;
                endcase
            end
        endcase
    endfunction

    // all three converter-side outputs against the prediction
    task automatic verify();
        check({2'h0, dac_code}, {2'h0, exp_dac});
        check({15'h0, user_logic_output}, {15'h0, exp_upo});
        check({15'h0, shutdown_active}, {15'h0, exp_hw_power_off_pin});
    endtask

    task automatic send(input logic [15:0] word);
        predict(word);
        serial_host_i.frame({word, 16'h0}, 16, 99);
    endtask

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard, well above the run length of the main sequence
    initial begin
        #1500000;
        n_mismatch++;
        complete_run();
    end

    // ******************************************************************
    // main sequence
    // ******************************************************************
    initial begin
        clk = 1'h0;
        rst_n = 1'h0;
        async_clear_input_n = 1'h1;
        clear_level_select = 1'h0;
        shutdown_lockout = 1'h0;
        hw_power_off_pin = 1'h0;
        {exp_in, exp_dac, exp_upo, exp_hw_power_off_pin} = 30'h0;
        n_mismatch = 0;
        comparisons = 0;
        sub_list = '{16'hC000, 16'hE800, 16'hC000, 16'hE000, 16'hE800};
        w = 16'($urandom(65226));
        repeat (20) @(negedge clk);
        rst_n = 1'h1;
        repeat (4) @(negedge clk);
        verify();
        for (int i = 0; i < 24; i++) begin
            w = 16'($urandom);
            w[15:14] = 2'(i % 3);
            send(w);
            verify();
        end
        send(16'h7FFF);
        verify();
        send(16'h4000);
        verify();
        // one word as two 8-bit packets
        w = {2'h1, 14'($urandom)};
        predict(w);
        serial_host_i.frame({w, 16'h0}, 16, 8);
        verify();
        // short word must leave everything alone
        serial_host_i.frame({16'h7FFF, 16'h0}, 8, 99);
        verify();
        foreach (sub_list[k]) begin
            send(sub_list[k]);
            verify();
        end
        send(16'hD000);
        verify();
        // shutdown keeps output; lockout fall exits
        shutdown_lockout = 1'h1;
        repeat (4) @(negedge clk);
        send(16'hD000);
        verify();
        shutdown_lockout = 1'h0;
        repeat (8) @(negedge clk);
        exp_hw_power_off_pin = 1'h0;
        verify();
        // hardware pin enters; load-both also leaves
        shutdown_lockout = 1'h1;
        hw_power_off_pin = 1'h1;
        repeat (8) @(negedge clk);
        hw_power_off_pin = 1'h0;
        repeat (8) @(negedge clk);
        exp_hw_power_off_pin = 1'h1;
        verify();
        send({2'h1, 14'($urandom)});
        verify();
        shutdown_lockout = 1'h0;
        for (int m = 0; m < 2; m++) begin
            send(m == 1 ? 16'hF000 : 16'hF800);
            w1 = {2'h0, 14'($urandom)};
            w = {2'h0, 14'($urandom)};
            predict(w);
            serial_host_i.frame({w1, w}, 32, 99);
            verify();
            if (m == 1) check({1'h0, serial_host_i.rx_lo[14:0]},
                              {1'h0, w1[15:1]});
            else check(serial_host_i.rx_hi[15:0], w1);
        end
        for (int m = 0; m < 2; m++) begin
            send(16'hE800);
            clear_level_select = 1'(m);
            async_clear_input_n = 1'h0;
            repeat (8) @(negedge clk);
            exp_dac = (m == 1) ? `CLR_MID_CODE : `CLR_ZERO_CODE;
            exp_upo = `UPO_DEFAULT;
            verify();
            async_clear_input_n = 1'h1;
            repeat (4) @(negedge clk);
            send(16'h8000);
            verify();
        end
        complete_run();
    end
endmodule

`default_nettype wire
